/* File: verilog/sdi_lt_pkg.sv */
// constants and types shared by the loop-through and mode controller
package sdi_lt_pkg;

    // ****************************************************************
    // host register map
    // ****************************************************************
    localparam logic [11:0] ADDR_MODE_CTRL = 12'h0000;
    localparam logic [11:0] ADDR_FEATURE = 12'h0001;
    localparam logic [11:0] ADDR_STATUS = 12'h0002;
    localparam logic [11:0] ADDR_DRIVE = 12'h006D;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MODE_HOST_BIT = 0;
    localparam int MODE_SEL_LSB = 1;
    localparam int FEAT_NRZI_BIT = 0;
    localparam int FEAT_DESCR_BIT = 1;
    localparam int WORD_ERR_BIT = 9;
    localparam int WORD_K_BIT = 8;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] MODE_CTRL_RST = 16'h0000;
    localparam logic [15:0] FEATURE_ALL = 16'hFFFF;
    localparam logic [15:0] DRIVE_RST = 16'h0000;
    localparam logic [15:0] RDATA_ZERO = 16'h0000;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int WORD_W = 10;
    localparam int REG_W = 16;
    localparam int ADDR_W = 12;
    localparam int STAT_W = 6;

    // ****************************************************************
    // operating modes
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_VIDEO,
        MODE_ASI,
        MODE_THRU,
        MODE_STANDBY
    } op_mode_t;

endpackage

/* File: verilog/bit_deserializer.sv */
// serial to parallel word builder, first bit lands in the msb
`timescale 1ns/1ps
`default_nettype none
module bit_deserializer #(
    parameter int W = 10
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bit,
    input wire logic i_valid,
    output logic [W-1:0] o_word,
    output logic o_word_valid
);

    localparam int CW = $clog2(W);
    localparam logic [CW-1:0] CNT_LAST = CW'(W - 1);

    logic [W-1:0] shift_r;
    logic [CW-1:0] cnt_r;

    // ****************************************************************
    // shift and count
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            shift_r <= '0;
            cnt_r <= '0;
        end else if (i_valid) begin
            shift_r <= {shift_r[W-2:0], i_bit};
            if (cnt_r == CNT_LAST) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // ****************************************************************
    // word output
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_word <= '0;
            o_word_valid <= 1'b0;
        end else begin
            o_word_valid <= i_valid && (cnt_r == CNT_LAST);
            if (i_valid && (cnt_r == CNT_LAST)) begin
                o_word <= {shift_r[W-2:0], i_bit};
            end
        end
    end

endmodule
`default_nettype wire

/* File: verilog/sdi_loopthrough_mode_ctrl.sv */
// loop-through output select, operating modes and pin direction control
`timescale 1ns/1ps
`default_nettype none
module sdi_loopthrough_mode_ctrl
    import sdi_lt_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_SER_IN,
    input wire logic I_PLL_LOCK,
    input wire logic I_LOOP_OUT_ENABLE,
    input wire logic I_RETIME_SELECT,
    input wire logic I_STANDBY,
    input wire logic I_ASI_MODE_PIN,
    input wire logic I_VIDEO_BYPASS_PIN,
    input wire logic I_HOST_WR,
    input wire logic I_HOST_RD,
    input wire logic [ADDR_W-1:0] I_HOST_ADDR,
    input wire logic [REG_W-1:0] I_HOST_WDATA,
    output logic [REG_W-1:0] O_HOST_RDATA,
    output logic O_HOST_ACK,
    output logic O_HOST_REFUSED,
    output logic O_LOOP_SERIAL_OUT_P,
    output logic O_LOOP_SERIAL_OUT_N,
    output logic O_LOCKED,
    output logic O_ASI_MODE_PIN,
    output logic O_ASI_MODE_PIN_OE,
    output logic O_VIDEO_BYPASS_PIN,
    output logic O_VIDEO_BYPASS_PIN_OE,
    output logic [WORD_W-1:0] O_PARALLEL_OUT,
    output logic O_PARALLEL_OUT_OE,
    output logic [STAT_W-1:0] O_STATUS_OUT,
    output logic O_STATUS_OUT_OE,
    output logic O_PCLK,
    output logic O_PCLK_OE,
    output logic O_HOST_TEST_DATA_OUT,
    output logic O_HOST_TEST_DATA_OUT_OE,
    output logic [REG_W-1:0] O_DRIVE_STRENGTH
);

    logic buf_r;
    logic samp1_r;
    logic samp2_r;
    logic nrz_prev_r;
    logic [8:0] scr_r;
    logic strap_asi_r;
    logic strap_thru_r;
    logic [REG_W-1:0] mode_ctrl_r;
    logic [REG_W-1:0] feature_r;
    op_mode_t mode_r;
    op_mode_t mode_nxt;
    logic standby;
    logic refuse;
    logic nrz_bit;
    logic deser_bit;
    logic [WORD_W-1:0] deser_word;
    logic deser_valid;
    logic [WORD_W-1:0] asi_word;

    // ****************************************************************
    // 8b/10b decode: {err, k, hgf, edcba}
    // ****************************************************************
    function automatic logic [WORD_W-1:0] dec_8b10b(
        input logic [WORD_W-1:0] w
    );
        logic [4:0] lo;
        logic [2:0] hi;
        logic err;
        logic k;
        lo = 5'h00;
        hi = 3'h0;
        err = 1'b0;
        k = 1'b0;
        case (w[9:4])
            6'b100111, 6'b011000: lo = 5'd0;
            6'b011101, 6'b100010: lo = 5'd1;
            6'b101101, 6'b010010: lo = 5'd2;
            6'b110001: lo = 5'd3;
            6'b110101, 6'b001010: lo = 5'd4;
            6'b101001: lo = 5'd5;
            6'b011001: lo = 5'd6;
            6'b111000, 6'b000111: lo = 5'd7;
            6'b111001, 6'b000110: lo = 5'd8;
            6'b100101: lo = 5'd9;
            6'b010101: lo = 5'd10;
            6'b110100: lo = 5'd11;
            6'b001101: lo = 5'd12;
            6'b101100: lo = 5'd13;
            6'b011100: lo = 5'd14;
            6'b010111, 6'b101000: lo = 5'd15;
            6'b011011, 6'b100100: lo = 5'd16;
            6'b100011: lo = 5'd17;
            6'b010011: lo = 5'd18;
            6'b110010: lo = 5'd19;
            6'b001011: lo = 5'd20;
            6'b101010: lo = 5'd21;
            6'b011010: lo = 5'd22;
            6'b111010, 6'b000101: lo = 5'd23;
            6'b110011, 6'b001100: lo = 5'd24;
            6'b100110: lo = 5'd25;
            6'b010110: lo = 5'd26;
            6'b110110, 6'b001001: lo = 5'd27;
            6'b001110: lo = 5'd28;
            6'b101110, 6'b010001: lo = 5'd29;
            6'b011110, 6'b100001: lo = 5'd30;
            6'b101011, 6'b010100: lo = 5'd31;
            6'b001111, 6'b110000: begin
                lo = 5'd28;
                k = 1'b1;
            end
            default: err = 1'b1;
        endcase
        case (w[3:0])
            4'b1011, 4'b0100: hi = 3'd0;
            4'b1001, 4'b0110: hi = k ? {2'b00, ~w[0]} : 3'd1;
            4'b0101, 4'b1010: hi = k ? {1'b0, w[2], ~w[2]} : 3'd2;
            4'b1100, 4'b0011: hi = 3'd3;
            4'b1101, 4'b0010: hi = 3'd4;
            4'b1110, 4'b0001: hi = 3'd7;
            4'b0111, 4'b1000: hi = 3'd7;
            default: err = 1'b1;
        endcase
        if (k && (w[3:0] == 4'b1010 || w[3:0] == 4'b0101)) begin
            hi = w[9] ? 3'd5 : 3'd2;
        end
        if (k && (w[3:0] == 4'b1001 || w[3:0] == 4'b0110)) begin
            hi = w[9] ? 3'd6 : 3'd1;
        end
        return {err, k, hi, lo};
    endfunction

    // ****************************************************************
    // operating mode select
    // ****************************************************************
    assign standby = (mode_r == MODE_STANDBY);

    always_comb begin
        if (I_STANDBY) begin
            mode_nxt = MODE_STANDBY;
        end else if (mode_ctrl_r[MODE_HOST_BIT]) begin
            mode_nxt = op_mode_t'(mode_ctrl_r[MODE_SEL_LSB +: 2]);
        end else if (strap_asi_r) begin
            mode_nxt = MODE_ASI;
        end else if (strap_thru_r) begin
            mode_nxt = MODE_THRU;
        end else begin
            mode_nxt = MODE_VIDEO;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            mode_r <= MODE_VIDEO;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // mode pins are inputs in reset, so their levels are caught here
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            strap_asi_r <= I_ASI_MODE_PIN;
            strap_thru_r <= I_VIDEO_BYPASS_PIN;
        end
    end

    // ****************************************************************
    // host register access
    // ****************************************************************
    // the mode register stays writable so host standby can be left
    assign refuse = (I_STANDBY || standby) &&
        !(I_HOST_WR && !I_STANDBY && I_HOST_ADDR == ADDR_MODE_CTRL);

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            mode_ctrl_r <= MODE_CTRL_RST;
            O_DRIVE_STRENGTH <= DRIVE_RST;
        end else if (I_HOST_WR && !refuse) begin
            if (I_HOST_ADDR == ADDR_MODE_CTRL) begin
                mode_ctrl_r <= I_HOST_WDATA;
            end else if (I_HOST_ADDR == ADDR_DRIVE) begin
                O_DRIVE_STRENGTH <= I_HOST_WDATA;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            feature_r <= FEATURE_ALL;
        end else if (mode_nxt == MODE_VIDEO && mode_r != MODE_VIDEO) begin
            feature_r <= FEATURE_ALL;
        end else if (I_HOST_WR && !refuse &&
                I_HOST_ADDR == ADDR_FEATURE) begin
            feature_r <= I_HOST_WDATA;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            O_HOST_ACK <= 1'b0;
            O_HOST_REFUSED <= 1'b0;
            O_HOST_RDATA <= RDATA_ZERO;
        end else begin
            O_HOST_ACK <= I_HOST_WR || I_HOST_RD;
            O_HOST_REFUSED <= (I_HOST_WR || I_HOST_RD) && refuse;
            if (!I_HOST_RD || refuse) begin
                O_HOST_RDATA <= RDATA_ZERO;
            end else if (I_HOST_ADDR == ADDR_MODE_CTRL) begin
                O_HOST_RDATA <= mode_ctrl_r;
            end else if (I_HOST_ADDR == ADDR_FEATURE) begin
                O_HOST_RDATA <= feature_r;
            end else if (I_HOST_ADDR == ADDR_STATUS) begin
                O_HOST_RDATA <= {11'h000, strap_thru_r, strap_asi_r,
                    O_LOCKED, mode_r};
            end else if (I_HOST_ADDR == ADDR_DRIVE) begin
                O_HOST_RDATA <= O_DRIVE_STRENGTH;
            end else begin
                O_HOST_RDATA <= RDATA_ZERO;
            end
        end
    end

    // ****************************************************************
    // serial stages and loop-through output
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            buf_r <= 1'b0;
            samp1_r <= 1'b0;
            samp2_r <= 1'b0;
            O_LOCKED <= 1'b0;
        end else begin
            buf_r <= I_SER_IN;
            samp1_r <= I_SER_IN;
            samp2_r <= samp1_r;
            O_LOCKED <= I_PLL_LOCK && !I_STANDBY && !standby;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            O_LOOP_SERIAL_OUT_P <= 1'b1;
            O_LOOP_SERIAL_OUT_N <= 1'b1;
        end else if (!I_LOOP_OUT_ENABLE || I_STANDBY) begin
            O_LOOP_SERIAL_OUT_P <= 1'b1;
            O_LOOP_SERIAL_OUT_N <= 1'b1;
        end else if (I_RETIME_SELECT && !O_LOCKED) begin
            O_LOOP_SERIAL_OUT_P <= 1'b0;
            O_LOOP_SERIAL_OUT_N <= 1'b1;
        end else if (I_RETIME_SELECT) begin
            O_LOOP_SERIAL_OUT_P <= samp2_r;
            O_LOOP_SERIAL_OUT_N <= ~samp2_r;
        end else begin
            O_LOOP_SERIAL_OUT_P <= buf_r;
            O_LOOP_SERIAL_OUT_N <= ~buf_r;
        end
    end

    // ****************************************************************
    // parallel path: video decode then deserialize
    // ****************************************************************
    assign nrz_bit = feature_r[FEAT_NRZI_BIT] ? (samp2_r ^ nrz_prev_r) :
        samp2_r;

    always_comb begin
        case (mode_r)
            MODE_VIDEO: begin
                deser_bit = feature_r[FEAT_DESCR_BIT] ?
                    (nrz_bit ^ scr_r[3] ^ scr_r[8]) : nrz_bit;
            end
            default: deser_bit = samp2_r;
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            nrz_prev_r <= 1'b0;
            scr_r <= 9'h000;
        end else begin
            nrz_prev_r <= samp2_r;
            scr_r <= {scr_r[7:0], nrz_bit};
        end
    end

    bit_deserializer #(
        .W(WORD_W)
    ) u_deser (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_bit(deser_bit),
        .i_valid(!standby),
        .o_word(deser_word),
        .o_word_valid(deser_valid)
    );

    assign asi_word = dec_8b10b(deser_word);

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            O_PARALLEL_OUT <= '0;
            O_STATUS_OUT <= '0;
            O_PCLK <= 1'b0;
            O_HOST_TEST_DATA_OUT <= 1'b0;
        end else if (deser_valid && !standby) begin
            O_PCLK <= ~O_PCLK;
            O_HOST_TEST_DATA_OUT <= deser_word[0];
            case (mode_r)
                MODE_ASI: O_PARALLEL_OUT <= asi_word;
                default: O_PARALLEL_OUT <= deser_word;
            endcase
            O_STATUS_OUT <= {O_LOCKED, asi_word[WORD_K_BIT],
                asi_word[WORD_ERR_BIT], mode_r, 1'b1};
        end
    end

    // ****************************************************************
    // pin directions
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            O_PARALLEL_OUT_OE <= 1'b0;
            O_STATUS_OUT_OE <= 1'b0;
            O_PCLK_OE <= 1'b0;
            O_HOST_TEST_DATA_OUT_OE <= 1'b0;
            O_ASI_MODE_PIN_OE <= 1'b0;
            O_VIDEO_BYPASS_PIN_OE <= 1'b0;
            O_ASI_MODE_PIN <= 1'b0;
            O_VIDEO_BYPASS_PIN <= 1'b0;
        end else begin
            O_PARALLEL_OUT_OE <= 1'b1;
            O_STATUS_OUT_OE <= 1'b1;
            O_PCLK_OE <= 1'b1;
            O_HOST_TEST_DATA_OUT_OE <= 1'b1;
            O_ASI_MODE_PIN_OE <= 1'b1;
            O_VIDEO_BYPASS_PIN_OE <= 1'b1;
            O_ASI_MODE_PIN <= (mode_r == MODE_ASI);
            O_VIDEO_BYPASS_PIN <= (mode_r == MODE_THRU);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_live;
        I_LOOP_OUT_ENABLE && !I_STANDBY;
    endsequence

    sequence s_enter_video;
        (mode_r != MODE_VIDEO) ##1 (mode_r == MODE_VIDEO);
    endsequence

    property p_disable;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        !I_LOOP_OUT_ENABLE |=> O_LOOP_SERIAL_OUT_P && O_LOOP_SERIAL_OUT_N;
    endproperty
    a_disable: assert property (p_disable)
        else $error("loop output not disabled");

    property p_standby_off;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        I_STANDBY |=> O_LOOP_SERIAL_OUT_P && O_LOOP_SERIAL_OUT_N &&
            !O_LOCKED;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("standby did not disable loop output");

    property p_retimed;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        (s_live and (I_RETIME_SELECT && O_LOCKED && !$past(I_RST, 2))) |=>
            (O_LOOP_SERIAL_OUT_P == $past(I_SER_IN, 3)) &&
            (O_LOOP_SERIAL_OUT_N != O_LOOP_SERIAL_OUT_P);
    endproperty
    a_retimed: assert property (p_retimed)
        else $error("retimed output wrong");

    property p_buffered;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        (s_live and (!I_RETIME_SELECT && !$past(I_RST))) |=>
            O_LOOP_SERIAL_OUT_P == $past(I_SER_IN, 2);
    endproperty
    a_buffered: assert property (p_buffered)
        else $error("buffered output wrong");

    property p_mute;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        (s_live and (I_RETIME_SELECT && !O_LOCKED)) |=>
            !O_LOOP_SERIAL_OUT_P && O_LOOP_SERIAL_OUT_N;
    endproperty
    a_mute: assert property (p_mute)
        else $error("unlocked retimed output not muted");

    property p_refuse;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        (I_STANDBY && I_HOST_WR && I_HOST_ADDR == ADDR_DRIVE) |=>
            O_HOST_REFUSED && $stable(O_DRIVE_STRENGTH);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("standby host write not refused");

    property p_reset_hiz;
        @(posedge I_CLK_SYS)
        I_RST |=> !O_PARALLEL_OUT_OE && !O_PCLK_OE && !O_STATUS_OUT_OE;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz)
        else $error("data outputs driven in reset");

    property p_mode_pin_out;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        !I_RST ##1 !I_RST |-> O_ASI_MODE_PIN_OE && O_VIDEO_BYPASS_PIN_OE;
    endproperty
    a_mode_pin_out: assert property (p_mode_pin_out)
        else $error("mode pins not driven");

    property p_video_entry;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        s_enter_video |-> feature_r == FEATURE_ALL;
    endproperty
    a_video_entry: assert property (p_video_entry)
        else $error("features not enabled on video entry");

    property p_thru_raw;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        (deser_valid && mode_r == MODE_THRU) |=>
            O_PARALLEL_OUT == $past(deser_word);
    endproperty
    a_thru_raw: assert property (p_thru_raw)
        else $error("data-through word altered");

endmodule
`default_nettype wire

/* File: sim/sdi_eq_model.sv */
// behavioural equalizer feeding the serial input and the lock level
`timescale 1ns/1ps
`default_nettype none
module sdi_eq_model (
    input wire logic i_clk,
    input wire logic i_all_ones,
    input wire logic i_lock_req,
    output logic o_ser,
    output logic o_lock
);
    // ****************************************************************
    // serial pattern source
    // ****************************************************************
    // board straps the loop bandwidth pin; no logic involved
    // board supplies the 27 MHz reference; not modelled here
    logic [3:0] cnt = 4'h0;

    // a new bit every cycle, launched just after the falling edge
    always @(negedge i_clk) begin
        cnt <= cnt + 4'h1;
    end

    // pattern repeats every 8 cycles and changes on 6 of them, so a stale bit cannot pass; i_all_ones holds it at 1
    assign o_ser = i_all_ones | (cnt[0] ^ cnt[2]);

    // lock is dropped only when the bench asks for it
    assign o_lock = i_lock_req;
endmodule
`default_nettype wire

/* File: sim/sdi_loopthrough_mode_ctrl_tb_top.sv */
// self-checking bench for the loop-through and mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("BAD %0t got %h exp %h", $time, got, exp); \
    end \
end
module sdi_loopthrough_mode_ctrl_tb_top
    import sdi_lt_pkg::*;
;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic clk, rst, ser, lock_req, lock, all_ones, en, ret, stb;
    logic strap_asi, strap_vid, wr, rd, ack, refused, got_ak, got_rf;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata, rdata, drive, got_rd;
    logic p, n, locked, asi_o, asi_oe, vid_o, vid_oe, asi_pin, vid_pin;
    logic par_oe, stat_oe, pclk, pclk_oe, tdo, tdo_oe;
    logic [WORD_W-1:0] par;
    logic [STAT_W-1:0] stat;
    logic [3:0] hist;
    int failures, samples_checked;
    // rows: {enable, retime, standby, lock, kind}
    // kind 0 disabled, 1 buffered, 2 retimed, 3 muted
    localparam logic [5:0] ROWS [7] = '{6'h14, 6'h04, 6'h3c, 6'h36,
        6'h25, 6'h33, 6'h21};

    // ****************************************************************
    // design, partner and pin resolution
    // ****************************************************************
    assign asi_pin = asi_oe ? asi_o : strap_asi;
    assign vid_pin = vid_oe ? vid_o : strap_vid;

    sdi_eq_model eq (.i_clk(clk), .i_all_ones(all_ones),
        .i_lock_req(lock_req), .o_ser(ser), .o_lock(lock));

    sdi_loopthrough_mode_ctrl dut (.I_CLK_SYS(clk), .I_RST(rst),
        .I_SER_IN(ser), .I_PLL_LOCK(lock), .I_LOOP_OUT_ENABLE(en),
        .I_RETIME_SELECT(ret), .I_STANDBY(stb), .I_ASI_MODE_PIN(asi_pin),
        .I_VIDEO_BYPASS_PIN(vid_pin), .I_HOST_WR(wr), .I_HOST_RD(rd),
        .I_HOST_ADDR(addr), .I_HOST_WDATA(wdata), .O_HOST_RDATA(rdata),
        .O_HOST_ACK(ack), .O_HOST_REFUSED(refused),
        .O_LOOP_SERIAL_OUT_P(p), .O_LOOP_SERIAL_OUT_N(n),
        .O_LOCKED(locked), .O_ASI_MODE_PIN(asi_o),
        .O_ASI_MODE_PIN_OE(asi_oe), .O_VIDEO_BYPASS_PIN(vid_o),
        .O_VIDEO_BYPASS_PIN_OE(vid_oe), .O_PARALLEL_OUT(par),
        .O_PARALLEL_OUT_OE(par_oe), .O_STATUS_OUT(stat),
        .O_STATUS_OUT_OE(stat_oe), .O_PCLK(pclk), .O_PCLK_OE(pclk_oe),
        .O_HOST_TEST_DATA_OUT(tdo), .O_HOST_TEST_DATA_OUT_OE(tdo_oe),
        .O_DRIVE_STRENGTH(drive));

    // ****************************************************************
    // clock, serial history, watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        hist <= {hist[2:0], ser};
    end

    initial begin
        #(40 * 6000);
        failures++;
        summarize();
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic summarize();
        $display("failures %0d samples_checked %0d", failures,
            samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // one-cycle strobe, answer sampled at the falling edge half a cycle after the rising edge that takes it
    task automatic host(input logic w, input logic [ADDR_W-1:0] a,
        input logic [REG_W-1:0] d);
        @(negedge clk);
        wr = w;
        rd = ~w;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        got_rd = rdata;
        got_ak = ack;
        got_rf = refused;
    endtask

    function automatic logic [1:0] exp_pn(input logic [5:0] row,
        input logic [3:0] h);
        case (row[1:0])
            2'h0: exp_pn = 2'h3;
            2'h1: exp_pn = {h[1], ~h[1]};
            2'h2: exp_pn = {h[2], ~h[2]};
            default: exp_pn = 2'h1;
        endcase
    endfunction

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        {rst, en, ret, lock_req} = 4'hf;
        {stb, all_ones, strap_asi, strap_vid, wr, rd} = 6'h00;
        addr = 12'h000;
        wdata = 16'h0000;
        hist = 4'h0;
        wait_cyc(4);
        `CHK({p, n}, 2'h3)
        `CHK({par_oe, stat_oe, pclk_oe, tdo_oe}, 4'h0)
        `CHK({asi_oe, vid_oe}, 2'h0)
        rst = 1'b0;
        wait_cyc(1);
        `CHK({par_oe, stat_oe, pclk_oe, tdo_oe}, 4'hf)
        `CHK({asi_oe, vid_oe}, 2'h3)
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            {en, ret, stb, lock_req} = ROWS[i][5:2];
            wait_cyc(5);
            repeat (3) begin
                `CHK({p, n}, exp_pn(ROWS[i], hist))
                `CHK(locked, lock_req & ~stb)
                @(negedge clk);
            end
        end
        $display("test loop output done");
        lock_req = 1'b1;
        host(1'b1, ADDR_DRIVE, 16'h5a3c);
        `CHK({got_ak, got_rf, drive}, {2'h2, 16'h5a3c})
        host(1'b0, ADDR_DRIVE, 16'h0000);
        `CHK(got_rd, 16'h5a3c)
        host(1'b0, 12'h0abc, 16'h0000);
        `CHK(got_rd, RDATA_ZERO)
        stb = 1'b1;
        host(1'b1, ADDR_DRIVE, 16'h0f0f);
        `CHK({got_ak, got_rf, got_rd}, {2'h3, RDATA_ZERO})
        `CHK({drive, locked}, {16'h5a3c, 1'b0})
        stb = 1'b0;
        $display("test host access done");
        host(1'b1, ADDR_FEATURE, 16'h0000);
        host(1'b0, ADDR_FEATURE, 16'h0000);
        `CHK(got_rd, 16'h0000)
        host(1'b1, ADDR_MODE_CTRL, 16'h0005);
        all_ones = 1'b1;
        ret = 1'b0;
        wait_cyc(40);
        `CHK({vid_o, asi_o}, 2'h2)
        `CHK(par, 10'h3ff)
        host(1'b1, ADDR_MODE_CTRL, 16'h0003);
        wait_cyc(40);
        `CHK({vid_o, asi_o}, 2'h1)
        `CHK(par[WORD_ERR_BIT], 1'b1)
        host(1'b1, ADDR_MODE_CTRL, 16'h0001);
        host(1'b0, ADDR_FEATURE, 16'h0000);
        `CHK(got_rd, FEATURE_ALL)
        host(1'b1, ADDR_MODE_CTRL, 16'h0007);
        host(1'b0, ADDR_FEATURE, 16'h0000);
        `CHK({got_ak, got_rf, got_rd, locked}, {2'h3, RDATA_ZERO, 1'b0})
        host(1'b1, ADDR_MODE_CTRL, 16'h0001);
        `CHK({got_ak, got_rf}, 2'h2)
        $display("test modes done");
        strap_asi = 1'b1;
        rst = 1'b1;
        wait_cyc(3);
        rst = 1'b0;
        wait_cyc(2);
        `CHK({asi_oe, asi_o, vid_o}, 3'h6)
        {strap_asi, strap_vid, rst} = 3'h3;
        wait_cyc(3);
        rst = 1'b0;
        wait_cyc(2);
        `CHK({vid_oe, vid_o, asi_o}, 3'h6)
        $display("test strap done");
        summarize();
    end
endmodule
`default_nettype wire
